// ---- imw_params.svh ----
// imw_params.svh - register indices, field layout and reset values of the wakeup flag block
// assumes a 32-bit APB slave with one aligned word per register
// How it works
// - one status byte shows which internal module ended a stop mode
// - after low leakage stop, a set bit names the module that resumed code
// - after very low leakage stop, a set bit names the module that reset the chip
// - each bit shows the peripheral's own live flag, never a separate latched copy
// - the byte and its controls clear on the chip reset excluding wakeup reset
// - other resets leave the byte untouched
// - bit n reads 1 when module n was a wakeup source, else 0
// - only a module enabled as wakeup source can show a set bit
// - a per-module enable bit decides whether that module may wake the chip
// - module wakeup inputs pass with no glitch filter
`ifndef IMW_PARAMS_SVH
`define IMW_PARAMS_SVH
`define IMW_ADDR_W      12
`define IMW_NUM_MOD     8
`define IMW_STATUS_IDX  7
`define IMW_ENABLE_IDX  8
`define IMW_EVENT_IDX   9
`define IMW_MASK_IDX    10
`define IMW_EXIT_IDX    11
`define IMW_ENABLE_RST  8'h00
`define IMW_MASK_RST    8'h00
`define IMW_EXIT_LLS    2'h1
`define IMW_EXIT_VERY_LOW_LEAKAGE_STOP   2'h2
`endif

// ---- imw_pkg.sv ----
// imw_pkg - types of the wakeup flag block
// assumes imw_params.svh supplies the numbers
`include "imw_params.svh"
package imw_pkg;
  typedef logic [`IMW_NUM_MOD-1:0] imw_flags_t;
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_LLS  = 3'b010,
    ST_VERY_LOW_LEAKAGE_STOP = 3'b100
  } imw_state_e;
  typedef enum logic [2:0] {
    SEL_NONE, SEL_STATUS, SEL_ENABLE, SEL_EVENT, SEL_MASK, SEL_EXIT
  } imw_sel_e;
endpackage : imw_pkg

// ---- imw_wakeup_flags.sv ----
// imw_wakeup_flags - internal module wakeup status byte with APB access
// assumes one clock, presetn is the chip reset that excludes the wakeup reset
`timescale 1ns/1ns
`include "imw_params.svh"
module imw_wakeup_flags #(
  parameter int ADDR_W = `IMW_ADDR_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire imw_pkg::imw_flags_t module_wakeup_flag,
  input  wire logic              enter_lls,
  input  wire logic              enter_very_low_leakage_stop,
  output logic                   wake_irq_flow,
  output logic                   wake_reset_flow,
  output logic                   irq
);
  import imw_pkg::*;

  localparam int NM = `IMW_NUM_MOD;

  // address to register selector, used in setup and access phases
  function automatic imw_sel_e decode(input logic [ADDR_W-1:0] a);
    imw_sel_e s;
    s = SEL_NONE;
    if (a == ADDR_W'(`IMW_STATUS_IDX * 4)) begin
      s = SEL_STATUS;
    end else if (a == ADDR_W'(`IMW_ENABLE_IDX * 4)) begin
      s = SEL_ENABLE;
    end else if (a == ADDR_W'(`IMW_EVENT_IDX * 4)) begin
      s = SEL_EVENT;
    end else if (a == ADDR_W'(`IMW_MASK_IDX * 4)) begin
      s = SEL_MASK;
    end else if (a == ADDR_W'(`IMW_EXIT_IDX * 4)) begin
      s = SEL_EXIT;
    end
    return s;
  endfunction : decode

  imw_flags_t wake_enable;
  imw_flags_t next_wake_enable;
  imw_flags_t irq_mask;
  imw_flags_t next_irq_mask;
  imw_flags_t event_sticky;
  imw_flags_t next_event_sticky;
  imw_flags_t live_prev;
  imw_flags_t next_live_prev;
  imw_flags_t live_flags;
  imw_flags_t flag_rise;
  logic [31:0] next_prdata;
  logic [1:0]  exit_mode;
  logic [1:0]  next_exit_mode;
  imw_state_e  state;
  imw_state_e  next_state;
  logic        next_wake_irq_flow;
  logic        next_wake_reset_flow;
  imw_sel_e    sel;
  logic        setup_rd;
  logic        access;
  logic        access_wr;
  logic        access_rd;
  logic        any_wake;

  // live view of the peripheral flags, gated by enables, unfiltered
  assign live_flags = module_wakeup_flag & wake_enable;
  assign any_wake   = |live_flags;
  assign flag_rise  = live_flags & ~live_prev;

  assign sel       = decode(paddr);
  assign setup_rd  = psel && !penable && !pwrite;
  assign access    = psel && penable;
  assign access_wr = access && pwrite;
  assign access_rd = access && !pwrite;

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && (sel == SEL_NONE);
  assign irq     = |(event_sticky & irq_mask);

  // register bus: writes and read data capture
  always_comb begin
    next_wake_enable = wake_enable;
    next_irq_mask    = irq_mask;
    next_prdata      = prdata;
    if (access_wr) begin
      unique case (sel)
        SEL_ENABLE: next_wake_enable = pwdata[NM-1:0];
        SEL_MASK:   next_irq_mask    = pwdata[NM-1:0];
        default:    next_wake_enable = wake_enable;
      endcase
    end
    if (setup_rd) begin
      next_prdata = 32'h0000_0000;
      unique case (sel)
        SEL_STATUS: next_prdata[NM-1:0] = live_flags;
        SEL_ENABLE: next_prdata[NM-1:0] = wake_enable;
        SEL_EVENT:  next_prdata[NM-1:0] = event_sticky;
        SEL_MASK:   next_prdata[NM-1:0] = irq_mask;
        SEL_EXIT:   next_prdata[1:0]    = exit_mode;
        default:    next_prdata         = 32'h0000_0000;
      endcase
    end
  end

  // only presetn clears these; no other reset reaches the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_enable <= `IMW_ENABLE_RST;
      irq_mask    <= `IMW_MASK_RST;
      prdata      <= 32'h0000_0000;
    end else begin
      wake_enable <= next_wake_enable;
      irq_mask    <= next_irq_mask;
      prdata      <= next_prdata;
    end
  end

  // sticky events: read of the event register clears only what it returned
  always_comb begin
    next_live_prev    = live_flags;
    next_event_sticky = event_sticky;
    if (access_rd && sel == SEL_EVENT) begin
      next_event_sticky = event_sticky & ~prdata[NM-1:0];
    end
    next_event_sticky = next_event_sticky | flag_rise;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_prev    <= '0;
      event_sticky <= '0;
    end else begin
      live_prev    <= next_live_prev;
      event_sticky <= next_event_sticky;
    end
  end

  // stop mode tracking and wakeup requests to the power controller
  always_comb begin
    next_state           = state;
    next_exit_mode       = exit_mode;
    next_wake_irq_flow   = 1'b0;
    next_wake_reset_flow = 1'b0;
    unique case (state)
      ST_RUN: begin
        if (enter_very_low_leakage_stop) begin
          next_state = ST_VERY_LOW_LEAKAGE_STOP;
        end else if (enter_lls) begin
          next_state = ST_LLS;
        end
      end
      ST_LLS: begin
        if (any_wake) begin
          next_state         = ST_RUN;
          next_exit_mode     = `IMW_EXIT_LLS;
          next_wake_irq_flow = 1'b1;
        end
      end
      ST_VERY_LOW_LEAKAGE_STOP: begin
        if (any_wake) begin
          next_state           = ST_RUN;
          next_exit_mode       = `IMW_EXIT_VERY_LOW_LEAKAGE_STOP;
          next_wake_reset_flow = 1'b1;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= ST_RUN;
      exit_mode       <= 2'h0;
      wake_irq_flow   <= 1'b0;
      wake_reset_flow <= 1'b0;
    end else begin
      state           <= next_state;
      exit_mode       <= next_exit_mode;
      wake_irq_flow   <= next_wake_irq_flow;
      wake_reset_flow <= next_wake_reset_flow;
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence seq_read_setup(imw_sel_e s);
    setup_rd && (sel == s);
  endsequence

  sequence seq_lls_wake;
    (state == ST_LLS) && any_wake;
  endsequence

  sequence seq_very_low_leakage_stop_wake;
    (state == ST_VERY_LOW_LEAKAGE_STOP) && any_wake;
  endsequence

  property p_status_read;
    seq_read_setup(SEL_STATUS) |=>
      prdata == {24'h00_0000, $past(module_wakeup_flag & wake_enable)};
  endproperty

  a_status_mirror: assert property (p_status_read)
    else $error("status read does not mirror enabled flags");

  a_lls_wake_irq: assert property (
    seq_lls_wake |=> wake_irq_flow && !wake_reset_flow ##1 !wake_irq_flow)
    else $error("low leakage wake did not raise one interrupt flow pulse");

  a_very_low_leakage_stop_wake_rst: assert property (
    seq_very_low_leakage_stop_wake |=> wake_reset_flow && !wake_irq_flow && exit_mode == `IMW_EXIT_VERY_LOW_LEAKAGE_STOP)
    else $error("very low leakage wake did not raise reset flow");

  a_disabled_no_wake: assert property (
    (state != ST_RUN) && ((module_wakeup_flag & wake_enable) == '0)
      |=> !wake_irq_flow && !wake_reset_flow)
    else $error("wake raised without an enabled flag");

  a_no_filter_delay: assert property (
    (state == ST_LLS) && $rose(any_wake) |=> state == ST_RUN)
    else $error("module wake input was delayed");

  a_enable_write: assert property (
    access_wr && sel == SEL_ENABLE |=> wake_enable == $past(pwdata[NM-1:0]))
    else $error("enable write not taken");

  a_status_wr_ignored: assert property (
    access_wr && sel == SEL_STATUS |=> $stable(wake_enable) && $stable(irq_mask))
    else $error("write to status byte changed state");

  a_bit_read_zero: assert property (
    seq_read_setup(SEL_STATUS) ##1 access_rd |-> prdata[31:NM] == '0)
    else $error("upper status bits not zero");

  a_event_irq: assert property (
    |(flag_rise & irq_mask) |=> irq ##0 (event_sticky & $past(flag_rise)) != '0)
    else $error("unmasked event did not raise irq");

  a_read_clears: assert property (
    access_rd && sel == SEL_EVENT && flag_rise == '0
      |=> (event_sticky & $past(prdata[NM-1:0])) == '0)
    else $error("event read did not clear returned bits");

  a_unmapped_err: assert property (
    access && sel == SEL_NONE |-> pslverr && pready)
    else $error("unmapped access without error");

  // entry and exit of the stop states
  a_enter_lls: assert property (
    state == ST_RUN && enter_lls && !enter_very_low_leakage_stop |=> state == ST_LLS)
    else $error("low leakage entry not taken");

  a_enter_very_low_leakage_stop: assert property (
    state == ST_RUN && enter_very_low_leakage_stop |=> state == ST_VERY_LOW_LEAKAGE_STOP)
    else $error("very low leakage entry not taken");

  a_exit_lls_mode: assert property (
    seq_lls_wake |=> exit_mode == `IMW_EXIT_LLS)
    else $error("low leakage exit not recorded");

  a_flows_exclusive: assert property (
    !(wake_irq_flow && wake_reset_flow))
    else $error("both wake flows raised together");

  a_lls_holds: assert property (
    state == ST_LLS && !any_wake |=> state == ST_LLS && !wake_irq_flow)
    else $error("low leakage stop left without a wake");

  a_very_low_leakage_stop_holds: assert property (
    state == ST_VERY_LOW_LEAKAGE_STOP && !any_wake |=> state == ST_VERY_LOW_LEAKAGE_STOP && !wake_reset_flow)
    else $error("very low leakage stop left without a wake");

  a_irq_flow_single: assert property (
    wake_irq_flow |=> !wake_irq_flow)
    else $error("interrupt flow pulse longer than one cycle");

  a_reset_flow_single: assert property (
    wake_reset_flow |=> !wake_reset_flow)
    else $error("reset flow pulse longer than one cycle");

  // bus side: what reads and writes may and may not touch
  a_status_enabled_only: assert property (
    seq_read_setup(SEL_STATUS) |=> (prdata[NM-1:0] & ~$past(wake_enable)) == '0)
    else $error("status shows a disabled module");

  a_status_rd_pure: assert property (
    access_rd && sel == SEL_STATUS |=> $stable(wake_enable) && $stable(irq_mask))
    else $error("status read changed state");

  a_mask_write: assert property (
    access_wr && sel == SEL_MASK |=> irq_mask == $past(pwdata[NM-1:0]))
    else $error("mask write not taken");

  a_unmapped_zero: assert property (
    seq_read_setup(SEL_NONE) |=> prdata == 32'h0000_0000)
    else $error("unmapped read data not zero");

  a_ro_wr_ignored: assert property (
    access_wr && (sel == SEL_EVENT || sel == SEL_EXIT)
      |=> $stable(wake_enable) && $stable(irq_mask))
    else $error("write to read-only register changed state");

endmodule : imw_wakeup_flags

// ---- imw_periph_model.sv ----
// imw_periph_model - peripherals holding wakeup flags, plus the power controller
// assumes the bench commands flag rises, peripheral clears and stop entries
`timescale 1ns/1ns
module imw_periph_model (
  input  wire logic                pclk,
  input  wire imw_pkg::imw_flags_t raise,
  input  wire imw_pkg::imw_flags_t lower,
  input  wire logic                go_lls,
  input  wire logic                go_very_low_leakage_stop,
  output imw_pkg::imw_flags_t      module_wakeup_flag,
  output logic                     enter_lls,
  output logic                     enter_very_low_leakage_stop
);
  import imw_pkg::*;
  initial begin
    module_wakeup_flag = '0;
    enter_lls = 1'b0;
    enter_very_low_leakage_stop = 1'b0;
  end
  // flags live in the peripherals and are cleared only there
  always @(posedge pclk) begin
    module_wakeup_flag <= (module_wakeup_flag & ~lower) | raise;
    enter_lls <= go_lls;
    enter_very_low_leakage_stop <= go_very_low_leakage_stop;
  end
endmodule : imw_periph_model

// ---- testbench.sv ----
// testbench - register and wakeup tests of the wakeup flag block
// assumes the peripheral model drives flags and stop entries
`timescale 1ns/1ns
`include "imw_params.svh"
module testbench;
  import imw_pkg::*;
  localparam logic [11:0] A_ST = 12'(4 * `IMW_STATUS_IDX);
  localparam logic [11:0] A_EN = 12'(4 * `IMW_ENABLE_IDX);
  localparam logic [11:0] A_EV = 12'(4 * `IMW_EVENT_IDX);
  localparam logic [11:0] A_MK = 12'(4 * `IMW_MASK_IDX);
  localparam logic [11:0] A_EX = 12'(4 * `IMW_EXIT_IDX);
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, go_lls = 1'b0, go_very_low_leakage_stop = 1'b0, wi, wr, err;
  logic        pready, pslverr, wake_irq_flow, wake_reset_flow, irq, enter_lls, enter_very_low_leakage_stop;
  logic [11:0] paddr = '0;
  logic [11:0] regs [5] = '{A_ST, A_EN, A_EV, A_MK, A_EX};
  logic [31:0] pwdata = '0, prdata, rdv;
  imw_flags_t  raise = '0, lower = '0, module_wakeup_flag, bit_k;
  int          bad_count = 0, comparisons = 0;
  always #25 pclk = ~pclk;
  imw_wakeup_flags imw_wakeup_flags_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .module_wakeup_flag(module_wakeup_flag),
    .enter_lls(enter_lls), .enter_very_low_leakage_stop(enter_very_low_leakage_stop), .wake_irq_flow(wake_irq_flow),
    .wake_reset_flow(wake_reset_flow), .irq(irq));
  imw_periph_model imw_periph_model_i (.pclk(pclk), .raise(raise), .lower(lower),
    .go_lls(go_lls), .go_very_low_leakage_stop(go_very_low_leakage_stop), .module_wakeup_flag(module_wakeup_flag),
    .enter_lls(enter_lls), .enter_very_low_leakage_stop(enter_very_low_leakage_stop));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    check(what, rdv, exp);
    check("read error", err, 1'b0);
  endtask : rd
  task automatic flags(input imw_flags_t up, input imw_flags_t down);
    raise <= up;
    lower <= down;
    @(posedge pclk);
    raise <= '0;
    lower <= '0;
  endtask : flags
  // gathers any wake pulse over a window
  task automatic watch();
    wi = 1'b0;
    wr = 1'b0;
    repeat (6) begin
      @(negedge pclk);
      wi |= wake_irq_flow;
      wr |= wake_reset_flow;
    end
    @(posedge pclk);
  endtask : watch
  task automatic irq_is(input logic exp);
    @(negedge pclk);
    check("irq", irq, exp);
    @(posedge pclk);
  endtask : irq_is
  task automatic conclude();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (2000) @(posedge pclk);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, A_EV, 32'hff);
    apb(1'b1, A_EX, 32'hff);
    for (int i = 0; i < 5; i++) rd("reset value", regs[i], 32'h0);
    apb(1'b0, 12'h030, '0);
    check("unmapped error", err, 1'b1);
    check("unmapped data", rdv, 32'h0);
    flags(8'ha5, 8'h00);
    apb(1'b1, A_EN, 32'h0f);
    rd("status live", A_ST, 32'h05);
    apb(1'b1, A_ST, 32'hff);
    rd("status after write", A_ST, 32'h05);
    flags(8'h00, 8'h01);
    rd("status after clear", A_ST, 32'h04);
    for (int m = 0; m < 2; m++) begin
      bit_k = (m == 0) ? 8'h01 : 8'h80;
      flags(8'h00, 8'hff);
      apb(1'b1, A_EN, {24'h0, bit_k});
      apb(1'b1, A_MK, 32'hff);
      apb(1'b0, A_EV, '0);
      go_lls <= (m == 0);
      go_very_low_leakage_stop <= (m == 1);
      @(posedge pclk);
      go_lls <= 1'b0;
      go_very_low_leakage_stop <= 1'b0;
      flags(~bit_k, 8'h00);
      watch();
      check("disabled wake", {wi, wr}, 2'b00);
      flags(bit_k, 8'h00);
      watch();
      check("lls wake", wi, m == 0);
      check("very_low_leakage_stop wake", wr, m == 1);
      rd("status source", A_ST, {24'h0, bit_k});
      rd("exit mode", A_EX, (m == 0) ? {30'h0, `IMW_EXIT_LLS} : {30'h0, `IMW_EXIT_VERY_LOW_LEAKAGE_STOP});
      irq_is(1'b1);
      rd("event", A_EV, {24'h0, bit_k});
      irq_is(1'b0);
    end
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("status after reset", A_ST, 32'h0);
    rd("exit after reset", A_EX, 32'h0);
    conclude();
  end
endmodule : testbench
